// *** protect_error_response_defines.svh ***
// Bit positions, reset values and message codes for the protection error response block
`ifndef PROTECT_ERROR_RESPONSE_DEFINES_SVH
`define PROTECT_ERROR_RESPONSE_DEFINES_SVH

`define CFG_RESET          8'h00
`define BIT_FIXED_LIMIT    3'd7
`define BIT_PROT_DETECT    3'd6
`define BIT_ESR_ENABLE     3'd5
`define BIT_ESE_PRESET     3'd4
`define BIT_PROT_MESSAGE   3'd3
`define BIT_PROT_OFF       3'd2
`define BIT_MEAS_MESSAGE   3'd1
`define BIT_MEAS_ACTION    3'd0
`define ESE_PRESET_PROT    8'h48
`define ESE_PRESET_PLAIN   8'h08
`define ESR_PROT_BIT       3'd6
`define MSG_CURR_PROT      10'h12F
`define MSG_VOLT_PROT      10'h130
`define MSG_NONE           10'h000

`endif

// *** protect_error_response_pkg.sv ***
// Types shared by the protection error response block
package protect_error_response_pkg;
  typedef logic [7:0] cfg_byte_t;
  typedef logic [9:0] msg_code_t;
endpackage

// *** cfg_byte_reg.sv ***
// One 8-bit error-response setting with write strobe and read-back
`include "protect_error_response_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cfg_byte_reg
  import protect_error_response_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire logic      wr_en,
  input  wire cfg_byte_t wr_data,
  output var  cfg_byte_t value
);
  cfg_byte_t value_q;
  cfg_byte_t value_d;

  always_comb begin
    value_d = value_q;
    if (wr_en) begin
      value_d = wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value_q <= `CFG_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;
endmodule // cfg_byte_reg
`default_nettype wire

// *** channel_error_reactor.sv ***
// Turns one channel's setting and error inputs into registered responses
`include "protect_error_response_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module channel_error_reactor
  import protect_error_response_pkg::*;
#(
  parameter msg_code_t PROT_MSG = `MSG_NONE
) (
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire cfg_byte_t cfg,
  input  wire logic      prot_err,
  input  wire logic      meas_err,
  input  wire logic      mode_match,
  output var  logic      prot_event,
  output var  logic      prot_msg_stb,
  output var  msg_code_t prot_msg_code,
  output var  logic      prot_off,
  output var  logic      meas_msg_stb,
  output var  logic      meas_action
);
  logic      prot_hit;
  logic      meas_hit;
  logic      ev_q, pm_q, po_q, mm_q, ma_q;
  logic      ev_d, pm_d, po_d, mm_d, ma_d;
  msg_code_t code_q, code_d;

  always_comb begin
    prot_hit = prot_err && cfg[`BIT_PROT_DETECT];
    meas_hit = meas_err && mode_match;
    ev_d     = prot_hit;
    pm_d     = prot_hit && cfg[`BIT_PROT_MESSAGE];
    code_d   = pm_d ? PROT_MSG : `MSG_NONE;
    po_d     = prot_hit && cfg[`BIT_PROT_OFF];
    mm_d     = meas_hit && cfg[`BIT_MEAS_MESSAGE];
    ma_d     = meas_hit && cfg[`BIT_MEAS_ACTION];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_q   <= 1'b0;
      pm_q   <= 1'b0;
      code_q <= `MSG_NONE;
      po_q   <= 1'b0;
      mm_q   <= 1'b0;
      ma_q   <= 1'b0;
    end else begin
      ev_q   <= ev_d;
      pm_q   <= pm_d;
      code_q <= code_d;
      po_q   <= po_d;
      mm_q   <= mm_d;
      ma_q   <= ma_d;
    end
  end

  assign prot_event    = ev_q;
  assign prot_msg_stb  = pm_q;
  assign prot_msg_code = code_q;
  assign prot_off      = po_q;
  assign meas_msg_stb  = mm_q;
  assign meas_action   = ma_q;
endmodule // channel_error_reactor
`default_nettype wire

// *** protect_error_response_cfg.sv ***
// Current and voltage error-response settings and the reactions they steer
// Function
// - 8-bit current setting, any value 00..FF, resets to 0.
// - Current bit 7 applies fixed current limit while output is on.
// - Current bit 6 enables current protection error detection.
// - Current bit 5 enables current protect bit in event status and enable.
// - Current bit 4 presets event enable to 72 or 8 at reset.
// - Current bit 3 makes protection error raise message 303.
// - Current bit 2 turns output off on protection error.
// - Current bit 1 raises device error on measurement error in current mode.
// - Current bit 0 shuts unit down on measurement error in current mode.
// - Current setting query returns exactly one byte.
// - 8-bit voltage setting, any value 00..FF, resets to 0.
// - Voltage bit 7 applies fixed voltage limit while output is on.
// - Voltage bit 6 enables voltage protection error detection.
// - Voltage bit 3 makes protection error raise message 304.
// - Voltage bit 2 turns output off on protection error.
// - Voltage bit 1 raises device error on measurement error in voltage mode.
// - Voltage bit 0 lets that device error turn output off.
// - Voltage setting query returns exactly one byte.
`include "protect_error_response_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module protect_error_response_cfg
  import protect_error_response_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire logic      curr_cfg_wr,
  input  wire logic      volt_cfg_wr,
  input  wire cfg_byte_t cfg_wr_data,
  input  wire logic      curr_cfg_rd,
  input  wire logic      volt_cfg_rd,
  input  wire logic      ese_preset,
  input  wire logic      output_on,
  input  wire logic      current_mode,
  input  wire logic      curr_prot_err,
  input  wire logic      volt_prot_err,
  input  wire logic      curr_meas_err,
  input  wire logic      volt_meas_err,
  output var  cfg_byte_t rd_data,
  output var  logic      rd_valid,
  output var  logic      fixed_curr_limit,
  output var  logic      fixed_volt_limit,
  output var  logic      esr_prot_enable,
  output var  logic      esr_prot_set,
  output var  logic      ese_load,
  output var  cfg_byte_t ese_load_value,
  output var  logic      err_msg_stb,
  output var  msg_code_t err_msg_code,
  output var  logic      dev_err_stb,
  output var  logic      force_output_off,
  output var  logic      unit_shutdown
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings storage
  cfg_byte_t curr_cfg;
  cfg_byte_t volt_cfg;

  cfg_byte_reg u_curr_cfg (
    .clk     (clk),
    .resetn  (resetn),
    .wr_en   (curr_cfg_wr),
    .wr_data (cfg_wr_data),
    .value   (curr_cfg)
  );

  // Bits 5 and 4 kept but unused here
  cfg_byte_reg u_volt_cfg (
    .clk     (clk),
    .resetn  (resetn),
    .wr_en   (volt_cfg_wr),
    .wr_data (cfg_wr_data),
    .value   (volt_cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel reactions; inputs assumed on this clock
  logic      c_ev, c_pm, c_po, c_mm, c_ma;
  logic      v_ev, v_pm, v_po, v_mm, v_ma;
  msg_code_t c_code, v_code;

  channel_error_reactor #(.PROT_MSG(`MSG_CURR_PROT)) u_curr (
    .clk           (clk),
    .resetn        (resetn),
    .cfg           (curr_cfg),
    .prot_err      (curr_prot_err),
    .meas_err      (curr_meas_err),
    .mode_match    (current_mode),
    .prot_event    (c_ev),
    .prot_msg_stb  (c_pm),
    .prot_msg_code (c_code),
    .prot_off      (c_po),
    .meas_msg_stb  (c_mm),
    .meas_action   (c_ma)
  );

  channel_error_reactor #(.PROT_MSG(`MSG_VOLT_PROT)) u_volt (
    .clk           (clk),
    .resetn        (resetn),
    .cfg           (volt_cfg),
    .prot_err      (volt_prot_err),
    .meas_err      (volt_meas_err),
    .mode_match    (!current_mode),
    .prot_event    (v_ev),
    .prot_msg_stb  (v_pm),
    .prot_msg_code (v_code),
    .prot_off      (v_po),
    .meas_msg_stb  (v_mm),
    .meas_action   (v_ma)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  cfg_byte_t rd_data_q, rd_data_d;
  logic      rd_valid_q, rd_valid_d;
  logic      fcl_q, fcl_d, fvl_q, fvl_d;
  logic      esr_en_q, esr_en_d, esr_set_q, esr_set_d;
  logic      ese_ld_q, ese_ld_d;
  cfg_byte_t ese_val_q, ese_val_d;
  logic      msg_q, msg_d;
  msg_code_t code_q, code_d;
  logic      dev_q, dev_d, off_q, off_d, shut_q, shut_d;
  logic      boot_q, boot_d;

  always_comb begin
    rd_valid_d = curr_cfg_rd || volt_cfg_rd;
    rd_data_d  = rd_data_q;
    if (curr_cfg_rd) begin
      rd_data_d = curr_cfg;
    end else if (volt_cfg_rd) begin
      rd_data_d = volt_cfg;
    end
    fcl_d     = curr_cfg[`BIT_FIXED_LIMIT] && output_on;
    fvl_d     = volt_cfg[`BIT_FIXED_LIMIT] && output_on;
    esr_en_d  = curr_cfg[`BIT_ESR_ENABLE];
    esr_set_d = c_ev && curr_cfg[`BIT_ESR_ENABLE];
    // First cycle after reset counts as power-up, plus explicit resets
    boot_d    = 1'b1;
    ese_ld_d  = (ese_preset || !boot_q) && curr_cfg[`BIT_ESE_PRESET];
    ese_val_d = curr_cfg[`BIT_ESR_ENABLE] ? `ESE_PRESET_PROT : `ESE_PRESET_PLAIN;
    // Current message wins a same-cycle clash; one code per strobe
    msg_d     = c_pm || v_pm;
    code_d    = c_pm ? c_code : v_code;
    dev_d     = c_mm || v_mm;
    off_d     = c_po || v_po || (v_mm && v_ma);
    shut_d    = c_ma;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q  <= `CFG_RESET;
      rd_valid_q <= 1'b0;
      fcl_q      <= 1'b0;
      fvl_q      <= 1'b0;
      esr_en_q   <= 1'b0;
      esr_set_q  <= 1'b0;
      ese_ld_q   <= 1'b0;
      ese_val_q  <= `ESE_PRESET_PLAIN;
      msg_q      <= 1'b0;
      code_q     <= `MSG_NONE;
      dev_q      <= 1'b0;
      off_q      <= 1'b0;
      shut_q     <= 1'b0;
      boot_q     <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      fcl_q      <= fcl_d;
      fvl_q      <= fvl_d;
      esr_en_q   <= esr_en_d;
      esr_set_q  <= esr_set_d;
      ese_ld_q   <= ese_ld_d;
      ese_val_q  <= ese_val_d;
      msg_q      <= msg_d;
      code_q     <= code_d;
      dev_q      <= dev_d;
      off_q      <= off_d;
      shut_q     <= shut_d;
      boot_q     <= boot_d;
    end
  end

  assign rd_data          = rd_data_q;
  assign rd_valid         = rd_valid_q;
  assign fixed_curr_limit = fcl_q;
  assign fixed_volt_limit = fvl_q;
  assign esr_prot_enable  = esr_en_q;
  assign esr_prot_set     = esr_set_q;
  assign ese_load         = ese_ld_q;
  assign ese_load_value   = ese_val_q;
  assign err_msg_stb      = msg_q;
  assign err_msg_code     = code_q;
  assign dev_err_stb      = dev_q;
  assign force_output_off = off_q;
  assign unit_shutdown    = shut_q;

endmodule // protect_error_response_cfg
`default_nettype wire

// *** protect_error_response_cfg_checker.sv ***
// Port-level assertions for the protection error response block
`timescale 1ns/1ps
`default_nettype none
module protect_error_response_cfg_checker
  import protect_error_response_pkg::*;
(
  input wire logic      clk,
  input wire logic      resetn,
  input wire logic      curr_cfg_wr,
  input wire cfg_byte_t cfg_wr_data,
  input wire logic      curr_cfg_rd,
  input wire logic      volt_cfg_rd,
  input wire logic      output_on,
  input wire logic      current_mode,
  input wire logic      curr_prot_err,
  input wire logic      volt_prot_err,
  input wire logic      curr_meas_err,
  input wire logic      volt_meas_err,
  input wire cfg_byte_t rd_data,
  input wire logic      rd_valid,
  input wire logic      fixed_curr_limit,
  input wire logic      fixed_volt_limit,
  input wire logic      esr_prot_enable,
  input wire logic      ese_load,
  input wire cfg_byte_t ese_load_value,
  input wire logic      err_msg_stb,
  input wire msg_code_t err_msg_code,
  input wire logic      dev_err_stb,
  input wire logic      force_output_off,
  input wire logic      unit_shutdown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  a_rd_valid_pulse: assert property (rd_valid == $past(curr_cfg_rd || volt_cfg_rd))
    else $error("read valid not one cycle after query");
  a_rd_data_hold: assert property (!$past(curr_cfg_rd || volt_cfg_rd) |-> $stable(rd_data))
    else $error("read data moved without query");
  a_curr_readback: assert property (curr_cfg_wr ##1 curr_cfg_rd |=> rd_data == $past(cfg_wr_data, 2))
    else $error("current setting read back wrong");
  a_fixed_limit_off: assert property (!$past(output_on) |-> !fixed_curr_limit && !fixed_volt_limit)
    else $error("fixed limit while output off");
  a_ese_value: assert property (ese_load |-> ese_load_value == (esr_prot_enable ? 8'h48 : 8'h08))
    else $error("event enable preset value wrong");
  a_curr_msg_code: assert property (err_msg_stb && !$past(volt_prot_err, 2) |-> err_msg_code == 10'h12F)
    else $error("current message code wrong");
  a_volt_msg_code: assert property (err_msg_stb && !$past(curr_prot_err, 2) |-> err_msg_code == 10'h130)
    else $error("voltage message code wrong");
  a_shutdown_cause: assert property (unit_shutdown |-> $past(curr_meas_err && current_mode, 2))
    else $error("shutdown without current mode error");
  a_dev_err_cause: assert property (dev_err_stb |->
    $past(curr_meas_err && current_mode || volt_meas_err && !current_mode, 2))
    else $error("device error without mode matched cause");
  a_force_off_cause: assert property (force_output_off |->
    $past(curr_prot_err || volt_prot_err || volt_meas_err && !current_mode, 2))
    else $error("output forced off without cause");
  c_query: cover property (curr_cfg_rd ##1 rd_valid);
  c_message: cover property (err_msg_stb);
  c_shutdown: cover property (unit_shutdown);
endmodule // protect_error_response_cfg_checker

bind protect_error_response_cfg protect_error_response_cfg_checker chk_i (.*);
`default_nettype wire

// *** protect_error_response_cfg_tb.sv ***
// Self-checking bench for the protection error response block
`timescale 1ns/1ps
`default_nettype none
module protect_error_response_cfg_tb;
  import protect_error_response_pkg::*;
  logic      clk, resetn, curr_cfg_wr, volt_cfg_wr, curr_cfg_rd, volt_cfg_rd, ese_preset, output_on;
  logic      current_mode, curr_prot_err, volt_prot_err, curr_meas_err, volt_meas_err, rd_valid;
  logic      fixed_curr_limit, fixed_volt_limit, esr_prot_enable, esr_prot_set, ese_load;
  logic      err_msg_stb, dev_err_stb, force_output_off, unit_shutdown;
  cfg_byte_t cfg_wr_data, rd_data, ese_load_value;
  msg_code_t err_msg_code;
  cfg_byte_t pat [4] = '{8'hFF, 8'h30, 8'h0F, 8'hA5};
  int        num_errors = 0;
  int        checks_done = 0;
  int        cycles = 0;

  protect_error_response_cfg DUT (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs always move 1 ns after the edge, never on it
  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // Idle cycle after each access: no strobe is lowered and raised in one step
  task automatic wr(input logic v, input cfg_byte_t d);
    curr_cfg_wr = !v;
    volt_cfg_wr = v;
    cfg_wr_data = d;
    tick();
    curr_cfg_wr = 1'b0;
    volt_cfg_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic v, input cfg_byte_t exp);
    curr_cfg_rd = !v;
    volt_cfg_rd = v;
    tick();
    curr_cfg_rd = 1'b0;
    volt_cfg_rd = 1'b0;
    chk({7'h00, rd_valid, rd_data}, {7'h00, 1'b1, exp});
    tick();
  endtask

  // Stimulus s = {curr prot, volt prot, curr meas, volt meas, mode}
  task automatic run(input cfg_byte_t cc, input cfg_byte_t vc, input logic [4:0] s, input logic [14:0] exp);
    wr(1'b0, cc);
    wr(1'b1, vc);
    {curr_prot_err, volt_prot_err, curr_meas_err, volt_meas_err, current_mode} = s;
    tick();
    {curr_prot_err, volt_prot_err, curr_meas_err, volt_meas_err} = 4'h0;
    tick();
    chk({1'b0, esr_prot_set, err_msg_stb, err_msg_code, dev_err_stb, force_output_off, unit_shutdown}, {1'b0, exp});
  endtask

  task automatic ese(input cfg_byte_t c, input logic [8:0] exp);
    wr(1'b0, c);
    ese_preset = 1'b1;
    tick();
    ese_preset = 1'b0;
    chk({6'h00, esr_prot_enable, ese_load, ese_load ? ese_load_value : 8'h00}, {6'h00, c[5], exp});
  endtask

  task automatic close_out;
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Generous ceiling: the whole sequence needs well under 300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    {resetn, curr_cfg_wr, volt_cfg_wr, curr_cfg_rd, volt_cfg_rd, ese_preset, output_on} = 7'h00;
    {current_mode, curr_prot_err, volt_prot_err, curr_meas_err, volt_meas_err} = 5'h00;
    cfg_wr_data = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    chk({8'h00, ese_load_value}, 16'h0008);
    resetn = 1'b1;
    rd(1'b0, 8'h00);
    rd(1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, pat[i]);
      rd(1'b0, pat[i]);
      wr(1'b1, ~pat[i]);
      rd(1'b1, ~pat[i]);
    end
    wr(1'b0, 8'h80);
    wr(1'b1, 8'h80);
    output_on = 1'b1;
    tick();
    chk({14'h0000, fixed_curr_limit, fixed_volt_limit}, 16'h0003);
    wr(1'b0, 8'h7F);
    chk({14'h0000, fixed_curr_limit, fixed_volt_limit}, 16'h0001);
    output_on = 1'b0;
    tick();
    chk({14'h0000, fixed_curr_limit, fixed_volt_limit}, 16'h0000);
    ese(8'h30, 9'h148);
    ese(8'h10, 9'h108);
    ese(8'h20, 9'h000);
    run(8'h4C, 8'h00, 5'h10, {2'b01, 10'h12F, 3'b010});
    run(8'h0C, 8'h00, 5'h10, 15'h0000);
    run(8'h00, 8'h4C, 5'h08, {2'b01, 10'h130, 3'b010});
    run(8'h00, 8'h0C, 5'h08, 15'h0000);
    run(8'h48, 8'h48, 5'h18, {2'b01, 10'h12F, 3'b000});
    run(8'h60, 8'h00, 5'h10, {2'b10, 10'h000, 3'b000});
    run(8'h03, 8'h00, 5'h05, {2'b00, 10'h000, 3'b101});
    run(8'h03, 8'h00, 5'h04, 15'h0000);
    run(8'h00, 8'h03, 5'h02, {2'b00, 10'h000, 3'b110});
    run(8'h00, 8'h02, 5'h02, {2'b00, 10'h000, 3'b100});
    run(8'h00, 8'h03, 5'h03, 15'h0000);
    close_out();
  end
endmodule // protect_error_response_cfg_tb
`default_nettype wire
